// [shared/sideband_mask_id_map.svh]
// Register offsets, field positions, reset values and counts
`ifndef SIDEBAND_MASK_ID_MAP_SVH
`define SIDEBAND_MASK_ID_MAP_SVH

`define OFF_VENDOR_REV 8'h08
`define OFF_DEVICE_TYPE 8'h09
`define OFF_BLOCK_LEN 8'h0A
`define OFF_PROTECT_0 8'h0B
`define OFF_PROTECT_1 8'h0C
`define OFF_PROTECT_2 8'h0D
`define OFF_ECHO_0 8'h0E
`define OFF_ECHO_1 8'h0F
`define OFF_ECHO_2 8'h10

`define BLEN_RST 6'h08
`define PROTECT_RST 8'h00
`define PROTECT2_RST 4'h0
`define ECHO_RST 20'hFFFFF

`define REV_MSB 7
`define REV_LSB 4
`define VENDOR_MSB 3
`define VENDOR_LSB 0
`define DTYPE_MSB 7
`define DTYPE_LSB 6
`define PART_MSB 5
`define PART_LSB 0
`define BLEN_MSB 5
`define PROTECT2_MSB 3

`define OUT_COUNT 20
`define HUNDRED_COUNT 7
`define SHIFT_LEN 20

`endif

// [shared/sideband_mask_id_pkg.sv]
// Types shared by the mask and identification register bank
package sideband_mask_id_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef logic [19:0] out_vec_t;
   typedef logic [5:0] blen_t;
   typedef logic [6:0] hundred_vec_t;
endpackage

// [design/sideband_shift_capture.sv]
// Three-wire side-band shift register with load-time capture
`timescale 1ns/1ps
`default_nettype none
`include "sideband_mask_id_map.svh"
module sideband_shift_capture
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic i_sb_clk,
   input wire logic i_sb_data,
   input wire logic i_sb_load,
   output sideband_mask_id_pkg::out_vec_t o_echo
);
   import sideband_mask_id_pkg::*;

   logic sb_clk_ff;
   logic sb_load_ff;
   out_vec_t shift_ff;
   out_vec_t echo_ff;

   // Edges are found in the reference domain; pins are synchronous
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sb_clk_ff <= 1'b0;
         sb_load_ff <= 1'b0;
      end
      else if (i_clk_en)
      begin
         sb_clk_ff <= i_sb_clk;
         sb_load_ff <= i_sb_load;
      end
   end

   // First bit shifted in ends in the top position
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         shift_ff <= `ECHO_RST;
      else if (i_clk_en && i_sb_clk && !sb_clk_ff)
         shift_ff <= {shift_ff[`SHIFT_LEN-2:0], i_sb_data};
   end

   // All outputs enabled until the first load
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         echo_ff <= `ECHO_RST;
      else if (i_clk_en && i_sb_load && !sb_load_ff)
         echo_ff <= shift_ff; // see R9
   end

   assign o_echo = echo_ff;
endmodule
`default_nettype wire

// [design/sideband_mask_id_regs.sv]
// Identification, block-length and side-band mask register bank
//
// What this block does
// R1 - Read-only ID byte: revision code in upper nibble, vendor in lower.
// R2 - Read-only byte: two-bit device type above a six-bit part number.
// R3 - Six-bit block read length, resets to eight, host may rewrite it.
// R4 - Protect bit clear lets side-band interface disable its output.
// R5 - Protected output is disabled only by its enable bit or pin.
// R6 - Protect register 0: bit 7 selectable 8, bits 6..0 hundred MHz.
// R7 - Protect register 1: bits 7..0 selectable outputs 7..0.
// R8 - Protect register 2: platform time, 25 MHz 2..0, upper bits reserved.
// R9 - Side-band shift contents are captured into the echo registers.
// R10 - Echo zero turns the output off unless it is protected.
// R11 - Echo one runs output only with enable bit and pin low.
// R12 - Echo registers map like protect registers, read-only, set at reset.
// R13 - Reserved bits read zero and ignore host writes.
// R14 - Output on: enable bit, pin enable, and protect or echo set.
`timescale 1ns/1ps
`default_nettype none
`include "sideband_mask_id_map.svh"
module sideband_mask_id_regs
#(
   parameter logic [3:0] REVISION_CODE = 4'h1, // Arbitrary value
   parameter logic [3:0] VENDOR_CODE = 4'h5, // Arbitrary value
   parameter logic [1:0] DEVICE_TYPE = 2'h0, // Arbitrary value
   parameter logic [5:0] PART_NUMBER = 6'h2A // Arbitrary value
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire sideband_mask_id_pkg::reg_byte_t i_reg_wdata,
   input wire logic i_reg_rd,
   output sideband_mask_id_pkg::reg_byte_t o_reg_rdata,
   output logic o_reg_rvalid,
   output sideband_mask_id_pkg::blen_t o_block_read_len,
   input wire logic i_sb_clk,
   input wire logic i_sb_data,
   input wire logic i_sb_load,
   input wire sideband_mask_id_pkg::out_vec_t i_smb_oe,
   input wire sideband_mask_id_pkg::hundred_vec_t i_hundred_oe_n,
   output sideband_mask_id_pkg::out_vec_t o_out_en
);
   import sideband_mask_id_pkg::*;

   blen_t blen_ff;
   reg_byte_t protect0_ff;
   reg_byte_t protect1_ff;
   logic [`PROTECT2_MSB:0] protect2_ff;
   reg_byte_t rdata_ff;
   reg_byte_t nxt_rdata;
   logic rvalid_ff;
   out_vec_t echo;
   out_vec_t protect_vec;
   out_vec_t pin_ok;
   out_vec_t out_en_ff;
   out_vec_t nxt_out_en;

   function automatic logic write_hit(input logic [7:0] addr,
                                      input logic [7:0] off);
      return addr == off;
   endfunction

   sideband_shift_capture u_shift
   (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_clk_en(i_clk_en),
      .i_sb_clk(i_sb_clk),
      .i_sb_data(i_sb_data),
      .i_sb_load(i_sb_load),
      .o_echo(echo)
   );

   // Reserved bits 7..6 are never stored
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         blen_ff <= `BLEN_RST;
      else if (i_clk_en && i_reg_wr && write_hit(i_reg_addr, `OFF_BLOCK_LEN))
         blen_ff <= i_reg_wdata[`BLEN_MSB:0]; // see R3
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         protect0_ff <= `PROTECT_RST;
      else if (i_clk_en && i_reg_wr && write_hit(i_reg_addr, `OFF_PROTECT_0))
         protect0_ff <= i_reg_wdata; // see R6
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         protect1_ff <= `PROTECT_RST;
      else if (i_clk_en && i_reg_wr && write_hit(i_reg_addr, `OFF_PROTECT_1))
         protect1_ff <= i_reg_wdata; // see R7
   end

   // Upper nibble reserved: writes there are dropped
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         protect2_ff <= `PROTECT2_RST;
      else if (i_clk_en && i_reg_wr && write_hit(i_reg_addr, `OFF_PROTECT_2))
         protect2_ff <= i_reg_wdata[`PROTECT2_MSB:0]; // see R8 R13
   end

   // Read mux; unmapped offsets answer zero
   always_comb
   begin
      nxt_rdata = 8'h00;
      unique case (i_reg_addr)
         `OFF_VENDOR_REV:
         begin
            nxt_rdata[`REV_MSB:`REV_LSB] = REVISION_CODE; // see R1
            nxt_rdata[`VENDOR_MSB:`VENDOR_LSB] = VENDOR_CODE;
         end
         `OFF_DEVICE_TYPE:
         begin
            nxt_rdata[`DTYPE_MSB:`DTYPE_LSB] = DEVICE_TYPE; // see R2
            nxt_rdata[`PART_MSB:`PART_LSB] = PART_NUMBER;
         end
         `OFF_BLOCK_LEN: nxt_rdata[`BLEN_MSB:0] = blen_ff; // see R13
         `OFF_PROTECT_0: nxt_rdata = protect0_ff;
         `OFF_PROTECT_1: nxt_rdata = protect1_ff;
         `OFF_PROTECT_2: nxt_rdata[`PROTECT2_MSB:0] = protect2_ff;
         `OFF_ECHO_0: nxt_rdata = echo[7:0]; // see R12
         `OFF_ECHO_1: nxt_rdata = echo[15:8]; // see R12
         `OFF_ECHO_2: nxt_rdata[3:0] = echo[19:16];
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rdata_ff <= 8'h00;
      else if (i_clk_en && i_reg_rd)
         rdata_ff <= nxt_rdata;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rvalid_ff <= 1'b0;
      else if (i_clk_en)
         rvalid_ff <= i_reg_rd;
   end

   assign protect_vec = {protect2_ff, protect1_ff, protect0_ff};

   // Only the hundred-MHz outputs have an enable pin
   genvar g;
   generate
      for (g = 0; g < `OUT_COUNT; g++)
      begin : g_gate
         if (g < `HUNDRED_COUNT)
         begin : g_pin
            assign pin_ok[g] = !i_hundred_oe_n[g]; // see R11
         end
         else
         begin : g_nopin
            assign pin_ok[g] = 1'b1;
         end
         // Protect bit shields the output from the side-band echo
         assign nxt_out_en[g] = i_smb_oe[g] && pin_ok[g] &&
            (protect_vec[g] || echo[g]); // see R4 R5 R10 R14
      end
   endgenerate

   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         out_en_ff <= '0;
      else if (i_clk_en)
         out_en_ff <= nxt_out_en; // see R11 R14
   end

   assign o_reg_rdata = rdata_ff;
   assign o_reg_rvalid = rvalid_ff;
   assign o_block_read_len = blen_ff; // see R3
   assign o_out_en = out_en_ff;
endmodule
`default_nettype wire

// [verification/sideband_mask_id_regs_asserts.sv]
// Port checks for the mask and identification register bank
`timescale 1ns/1ps
`default_nettype none
module sideband_mask_id_regs_asserts
import sideband_mask_id_pkg::*;
#(
   // Identity values are arbitrary
   parameter logic [3:0] REVISION_CODE = 4'h1,
   parameter logic [3:0] VENDOR_CODE = 4'h5,
   parameter logic [1:0] DEVICE_TYPE = 2'h0,
   parameter logic [5:0] PART_NUMBER = 6'h2A
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_clk_en,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire sideband_mask_id_pkg::reg_byte_t i_reg_wdata,
   input wire logic i_reg_rd,
   input wire sideband_mask_id_pkg::reg_byte_t o_reg_rdata,
   input wire sideband_mask_id_pkg::blen_t o_block_read_len,
   input wire sideband_mask_id_pkg::out_vec_t i_smb_oe,
   input wire sideband_mask_id_pkg::hundred_vec_t i_hundred_oe_n,
   input wire sideband_mask_id_pkg::out_vec_t o_out_en
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   wire logic rd_go = i_reg_rd && i_clk_en;
   wire logic [5:0] wlen = i_reg_wdata[5:0];
   id_byte_a: assert property (
      rd_go && i_reg_addr == 8'h08 |=> o_reg_rdata == {REVISION_CODE,
      VENDOR_CODE}) else $error("id byte");
   type_byte_a: assert property (
      rd_go && i_reg_addr == 8'h09 |=> o_reg_rdata == {DEVICE_TYPE,
      PART_NUMBER}) else $error("type byte");
   blen_write_a: assert property (
      i_clk_en && i_reg_wr && i_reg_addr == 8'h0A |=>
      o_block_read_len == $past(wlen)) else $error("block length");
   prot2_rsvd_a: assert property (
      rd_go && i_reg_addr == 8'h0D |=> o_reg_rdata[7:4] == 4'h0)
      else $error("protect upper bits");
   echo2_rsvd_a: assert property (
      rd_go && i_reg_addr == 8'h10 |=> o_reg_rdata[7:4] == 4'h0)
      else $error("echo upper bits");
   unmapped_zero_a: assert property (
      rd_go && i_reg_addr > 8'h10 |=> o_reg_rdata == 8'h00)
      else $error("unmapped read");
   enable_gate_a: assert property (
      $past(i_clk_en) |-> (o_out_en & ~$past(i_smb_oe)) == 20'h00000)
      else $error("enable bit ignored");
   pin_gate_a: assert property (
      $past(i_clk_en) |-> (o_out_en[6:0] & $past(i_hundred_oe_n)) == 7'h00)
      else $error("pin ignored");
   cover property (rd_go && i_reg_addr == 8'h0E);
   cover property (i_reg_wr && i_reg_addr == 8'h0A);
   cover property (o_out_en != 20'h00000);
endmodule
bind sideband_mask_id_regs sideband_mask_id_regs_asserts #(
   .REVISION_CODE(REVISION_CODE), .VENDOR_CODE(VENDOR_CODE),
   .DEVICE_TYPE(DEVICE_TYPE), .PART_NUMBER(PART_NUMBER)) chk_i (.*);
`default_nettype wire

// [verification/smbus_host_model.sv]
// Host model issuing single-byte register writes and reads
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
import sideband_mask_id_pkg::*;
(
   input wire logic i_ref_clk,
   input wire sideband_mask_id_pkg::reg_byte_t i_rdata,
   input wire logic i_rvalid,
   output logic [7:0] o_addr,
   output logic o_wr,
   output sideband_mask_id_pkg::reg_byte_t o_wdata,
   output logic o_rd
);
   initial {o_addr, o_wr, o_wdata, o_rd} = 18'h00000;
   // Data inverted once released so stale bytes never look valid
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_ref_clk) {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
      @(negedge i_ref_clk) {o_wdata, o_wr} = {~d, 1'b0};
   endtask
   task automatic rd_byte(input logic [7:0] a, output logic [8:0] q);
      @(negedge i_ref_clk) {o_addr, o_rd} = {a, 1'b1};
      @(negedge i_ref_clk) o_rd = 1'b0;
      q = {i_rvalid, i_rdata};
   endtask
endmodule
`default_nettype wire

// [verification/test_sideband_mask_id_regs.sv]
// Self-checking bench for the mask and identification register bank
`timescale 1ns/1ps
`default_nettype none
module test_sideband_mask_id_regs;
   import sideband_mask_id_pkg::*;
   logic i_ref_clk, i_rst_n, i_clk_en, i_reg_wr, i_reg_rd, o_reg_rvalid;
   logic i_sb_clk, i_sb_data, i_sb_load;
   logic [7:0] i_reg_addr;
   logic [8:0] q;
   reg_byte_t i_reg_wdata, o_reg_rdata;
   blen_t o_block_read_len;
   out_vec_t i_smb_oe, o_out_en, echo, prot;
   hundred_vec_t i_hundred_oe_n;
   int fail_count = 0;
   int n_checks = 0;
   int mdl [8:17];
   int wm [8:17] = '{0, 0, 'h3F, 'hFF, 'hFF, 'hF, 0, 0, 0, 0};
   sideband_mask_id_regs sideband_mask_id_regs_i (.*);
   smbus_host_model smbus_host_model_i (.i_ref_clk, .i_rdata(o_reg_rdata),
      .i_rvalid(o_reg_rvalid), .o_addr(i_reg_addr), .o_wr(i_reg_wr),
      .o_wdata(i_reg_wdata), .o_rd(i_reg_rd));
   task automatic chk_byte(input reg_byte_t got, input int exp);
      n_checks++;
      if (got !== exp[7:0])
      begin
         fail_count++;
         $display("[FAIL] %0t byte %h exp %h", $time, got, exp[7:0]);
      end
   endtask
   task automatic chk_vec(input out_vec_t got, input out_vec_t exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t out %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input int a);
      smbus_host_model_i.rd_byte(a[7:0], q);
      chk_byte(q[8] ? q[7:0] : 8'hXX, mdl[a]);
   endtask
   task automatic wr_mdl(input int a, input int d);
      smbus_host_model_i.wr_byte(a[7:0], d[7:0]);
      mdl[a] = (d & wm[a]) | (mdl[a] & ~wm[a]);
   endtask
   // First bit shifted ends in the top position
   task automatic shift_in(input out_vec_t v);
      for (int i = 19; i >= 0; i--)
      begin
         @(negedge i_ref_clk) {i_sb_data, i_sb_clk} = {v[i], 1'b1};
         @(negedge i_ref_clk) i_sb_clk = 1'b0;
      end
      @(negedge i_ref_clk) i_sb_load = 1'b1;
      @(negedge i_ref_clk) i_sb_load = 1'b0;
   endtask
   task automatic print_verdict;
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end
   initial
   begin
      #50us;
      fail_count++;
      print_verdict;
   end
   initial
   begin
      {i_clk_en, i_sb_clk, i_sb_data, i_sb_load, i_rst_n} = 5'h10;
      i_smb_oe = 20'h00000;
      i_hundred_oe_n = 7'h7F;
      mdl = '{'h15, 'h2A, 'h08, 0, 0, 0, 'hFF, 'hFF, 'h0F, 0};
      void'($urandom(32'h5f70ef46));
      repeat (6) @(negedge i_ref_clk);
      i_rst_n = 1'b1;
      for (int a = 8; a < 18; a++) rd_chk(a);
      for (int a = 8; a < 18; a++) wr_mdl(a, 'hFF);
      for (int a = 8; a < 18; a++) rd_chk(a);
      repeat (20)
      begin
         for (int a = 10; a < 14; a++) wr_mdl(a, $urandom);
         echo = out_vec_t'($urandom);
         shift_in(echo);
         i_smb_oe = out_vec_t'($urandom);
         i_hundred_oe_n = hundred_vec_t'($urandom);
         mdl[14] = echo[7:0];
         mdl[15] = echo[15:8];
         mdl[16] = echo[19:16];
         repeat (2) @(negedge i_ref_clk);
         prot = {mdl[13][3:0], mdl[12][7:0], mdl[11][7:0]};
         chk_vec(o_out_en, i_smb_oe & {13'h1FFF, ~i_hundred_oe_n} &
            (prot | echo));
         for (int a = 10; a < 17; a++) rd_chk(a);
      end
      // Frozen clock enable must drop a write to the length byte
      i_clk_en = 1'b0;
      smbus_host_model_i.wr_byte(8'h0A, 8'(mdl[10] ^ 'h3F));
      @(negedge i_ref_clk) i_clk_en = 1'b1;
      chk_byte({2'b00, o_block_read_len}, mdl[10]);
      rd_chk(10);
      // Mid-run reset brings back the power-up values
      @(negedge i_ref_clk) i_rst_n = 1'b0;
      repeat (2) @(negedge i_ref_clk);
      i_rst_n = 1'b1;
      mdl = '{'h15, 'h2A, 'h08, 0, 0, 0, 'hFF, 'hFF, 'h0F, 0};
      for (int a = 8; a < 18; a++) rd_chk(a);
      chk_byte({2'b00, o_block_read_len}, 'h08);
      chk_vec(o_out_en, i_smb_oe & {13'h1FFF, ~i_hundred_oe_n});
      print_verdict;
   end
endmodule
`default_nettype wire
